// ### logic/pcp_sequencer.sv
// Program counter, return stack, status, bank pointer and data window with APB access
//
// Operation
// - Program counter and each return stack entry are 13 bits wide.
// - Program space splits into 1024-word pages picked by the top three bits.
// - Reset clears the whole program counter.
// - Jump loads its operand into the low 10 counter bits.
// - Call pushes next address, then loads operand into low 10 bits.
// - All three exit forms load the counter from the stack top.
// - Exits leave page-select untouched; return goes to the calling page.
// - Adding accumulator to counter is a 10-bit add carrying into bits 8 and 9 only.
// - Moving accumulator into counter replaces low 8 bits, keeps bits 8 and 9.
// - Every other counter write, bit ops included, keeps bits 8 and 9.
// - Jump, call and counter writes copy page-select into bits 12 to 10.
// - Page-select sits in status bits 7 to 5; page n spans n*0x400 onward.
// - One instruction cycle each at fclk/2 or fclk/4; rewrites take one or two.
// - Status bit 4 set by sleep, watchdog clear, power-on; cleared on timeout.
// - Status bit 3 set by power-on or watchdog clear, cleared by sleep.
// - Status bit 2 is zero flag, bit 1 nibble carry, bit 0 carry.
// - Bank pointer bits 7:6 pick bank, bits 5:0 pick indirect address.
// - Address zero is redirected to the register the bank pointer names.
`timescale 1ns/1ps
module pcp_sequencer #(
    parameter int STACK_DEPTH = 8,
    parameter int COMMON_BYTES = 16,
    parameter int BANKS = 4,
    parameter int BANK_BYTES = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcp_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_valid,
    input wire pcp_pkg::pcp_op_t op_code,
    input wire logic [pcp_pkg::ARG_W-1:0] op_arg,
    input wire logic wdt_timeout,
    output logic op_ready,
    output logic op_ack,
    output logic instr_tick,
    output logic exit_literal_load,
    output logic [pcp_pkg::BYTE_W-1:0] exit_literal,
    output logic irq_exit,
    output logic [pcp_pkg::PC_W-1:0] pc_addr,
    output logic [pcp_pkg::BYTE_W-1:0] status_out,
    output logic [pcp_pkg::BYTE_W-1:0] ram_bank_out
);

    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam int BANK_SEL_W = $clog2(BANKS);
    localparam int COMMON_W = $clog2(COMMON_BYTES);
    localparam int BANK_OFF_W = $clog2(BANK_BYTES);

    typedef struct packed {
        pcp_pkg::pcp_seq_t seq;
        logic [pcp_pkg::PC_W-1:0] pc;
        logic [7:0] status;
        logic [7:0] rbp;
        logic [1:0] cfg;
        logic [1:0] div_cnt;
        logic tick;
        logic [SP_W-1:0] sp;
        logic [SP_W:0] depth;
        logic overflow;
        logic underflow;
        logic [STACK_DEPTH-1:0][pcp_pkg::PC_W-1:0] stack;
        logic [COMMON_BYTES-1:0][7:0] common;
        logic [BANKS*BANK_BYTES-1:0][7:0] banked;
        logic op_ready;
        logic op_ack;
        logic lit_load;
        logic [7:0] lit;
        logic irq_exit;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pcp_state_t;

    localparam pcp_state_t STATE_RST = '{
        seq: pcp_pkg::SEQ_RUN,
        status: pcp_pkg::STATUS_RST,
        rbp: pcp_pkg::RBP_RST,
        cfg: pcp_pkg::CFG_RST,
        op_ready: 1'b1,
        default: '0
    };

    pcp_state_t state_reg;
    pcp_state_t state_next;

    // Data-space address after resolving the indirect slot
    function automatic logic [pcp_pkg::DADDR_W-1:0] resolve_addr(
        input logic [9:0] idx,
        input logic [7:0] rbp
    );
        resolve_addr = (idx == pcp_pkg::IDX_INDIRECT_SLOT) ? rbp[pcp_pkg::DADDR_W-1:0] : idx[5:0];
    endfunction : resolve_addr

    function automatic logic is_data_addr(input logic [9:0] idx);
        is_data_addr = (idx == pcp_pkg::IDX_INDIRECT_SLOT) || (idx == pcp_pkg::IDX_PROGRAM_COUNTER) ||
            (idx == pcp_pkg::IDX_STATUS_FLAGS) || (idx == pcp_pkg::IDX_RAM_BANK_POINTER) ||
            ((idx >= pcp_pkg::IDX_COMMON_FIRST) && (idx <= pcp_pkg::IDX_DATA_LAST));
    endfunction : is_data_addr

    function automatic logic [BANK_SEL_W+BANK_OFF_W-1:0] bank_index(
        input logic [pcp_pkg::DADDR_W-1:0] a,
        input logic [7:0] rbp
    );
        bank_index = {rbp[pcp_pkg::RBP_BANK_HI:pcp_pkg::RBP_BANK_LO], a[BANK_OFF_W-1:0]};
    endfunction : bank_index

    // Read of the resolved data space; address zero has nothing behind it
    function automatic logic [31:0] data_read(
        input logic [pcp_pkg::DADDR_W-1:0] a,
        input pcp_state_t s
    );
        data_read = 32'h0;
        if (a == pcp_pkg::IDX_PROGRAM_COUNTER[5:0]) begin
            data_read = {19'h0, s.pc};
        end else if (a == pcp_pkg::IDX_STATUS_FLAGS[5:0]) begin
            data_read = {24'h0, s.status};
        end else if (a == pcp_pkg::IDX_RAM_BANK_POINTER[5:0]) begin
            data_read = {24'h0, s.rbp};
        end else if (a >= pcp_pkg::IDX_BANKED_FIRST[5:0]) begin
            data_read = {24'h0, s.banked[bank_index(a, s.rbp)]};
        end else if (a >= pcp_pkg::IDX_COMMON_FIRST[5:0]) begin
            data_read = {24'h0, s.common[a[COMMON_W-1:0]]};
        end
    endfunction : data_read

    // Stack status word: sticky flags above the live depth
    function automatic logic [31:0] stack_info(input pcp_state_t s);
        stack_info = {24'h0, s.underflow, s.overflow, {(6 - SP_W - 1){1'b0}}, s.depth};
    endfunction : stack_info

    logic accept;
    logic [1:0] div_last;
    logic [pcp_pkg::PC_W-1:0] pc_inc;
    logic [pcp_pkg::PAGE_W-1:0] page;
    logic [pcp_pkg::PAGE_LO_W-1:0] rel_sum;
    logic [SP_W-1:0] top;
    logic rewrite;
    logic access;
    logic [9:0] idx;
    logic bus_ok;
    logic bus_answer;
    logic bus_write;
    logic call_overflow;
    logic exit_underflow;
    logic [pcp_pkg::DADDR_W-1:0] daddr;

    always_comb begin
        state_next = state_reg;
        state_next.op_ack = 1'b0;
        state_next.lit_load = 1'b0;
        state_next.irq_exit = 1'b0;
        rewrite = 1'b0;
        pc_inc = state_reg.pc + 13'h1;
        page = state_reg.status[pcp_pkg::ST_PAGE_HI:pcp_pkg::ST_PAGE_LO];
        rel_sum = pc_inc[pcp_pkg::PAGE_LO_W-1:0] + {2'h0, op_arg[7:0]};
        top = state_reg.sp - {{(SP_W-1){1'b0}}, 1'b1};

        // Instruction cycle enable: every 2 or 4 clocks
        div_last = state_reg.cfg[pcp_pkg::CFG_SLOW_CLK] ? pcp_pkg::DIV_SLOW_LAST : pcp_pkg::DIV_FAST_LAST;
        if (state_reg.div_cnt >= div_last) begin
            state_next.div_cnt = 2'h0;
            state_next.tick = 1'b1;
        end else begin
            state_next.div_cnt = state_reg.div_cnt + 2'h1;
            state_next.tick = 1'b0;
        end

        // Extra cycle of a counter rewrite ends on the next instruction tick
        if (state_reg.seq == pcp_pkg::SEQ_REWRITE && state_reg.tick) begin
            state_next.seq = pcp_pkg::SEQ_RUN;
            state_next.op_ready = 1'b1;
        end

        // Timeout clears first so a same-cycle set wins
        if (wdt_timeout) begin
            state_next.status[pcp_pkg::ST_TIMEOUT] = 1'b0;
        end

        accept = state_reg.tick && op_valid && state_reg.op_ready && (state_reg.seq == pcp_pkg::SEQ_RUN);
        // Stack edge events, shared by push/pop and the flag clear
        call_overflow = accept && (op_code == pcp_pkg::OP_CALL) && (state_reg.depth == STACK_DEPTH[SP_W:0]);
        exit_underflow = accept && (op_code inside {pcp_pkg::OP_EXIT, pcp_pkg::OP_EXIT_LIT, pcp_pkg::OP_EXIT_IRQ}) &&
            (state_reg.depth == '0);
        if (accept) begin
            state_next.op_ack = 1'b1;
            case (op_code)
                pcp_pkg::OP_JUMP: begin
                    state_next.pc = {page, op_arg};
                    rewrite = 1'b1;
                end
                pcp_pkg::OP_CALL: begin
                    state_next.stack[state_reg.sp] = pc_inc;
                    // Pointer wraps, so a push on a full stack replaces the oldest entry
                    state_next.sp = state_reg.sp + {{(SP_W-1){1'b0}}, 1'b1};
                    if (call_overflow) begin
                        state_next.overflow = 1'b1;
                    end else begin
                        state_next.depth = state_reg.depth + {{SP_W{1'b0}}, 1'b1};
                    end
                    state_next.pc = {page, op_arg};
                    rewrite = 1'b1;
                end
                pcp_pkg::OP_EXIT, pcp_pkg::OP_EXIT_LIT, pcp_pkg::OP_EXIT_IRQ: begin
                    state_next.pc = state_reg.stack[top];
                    // Empty pop still reads the stale slot below the pointer
                    state_next.sp = top;
                    if (exit_underflow) begin
                        state_next.underflow = 1'b1;
                    end else begin
                        state_next.depth = state_reg.depth - {{SP_W{1'b0}}, 1'b1};
                    end
                    state_next.lit_load = (op_code == pcp_pkg::OP_EXIT_LIT);
                    state_next.lit = op_arg[7:0];
                    state_next.irq_exit = (op_code == pcp_pkg::OP_EXIT_IRQ);
                    rewrite = 1'b1;
                end
                pcp_pkg::OP_ADD_PC: begin
                    state_next.pc = {page, rel_sum};
                    rewrite = 1'b1;
                end
                pcp_pkg::OP_MOV_PC: begin
                    state_next.pc = {page, state_reg.pc[9:8], op_arg[7:0]};
                    rewrite = 1'b1;
                end
                pcp_pkg::OP_WRITE_PC: begin
                    state_next.pc = {page, state_reg.pc[9:8], op_arg[7:0]};
                    rewrite = 1'b1;
                end
                pcp_pkg::OP_SLEEP: begin
                    state_next.pc = pc_inc;
                    state_next.status[pcp_pkg::ST_TIMEOUT] = 1'b1;
                    state_next.status[pcp_pkg::ST_HALT] = 1'b0;
                end
                pcp_pkg::OP_WDT_CLEAR: begin
                    state_next.pc = pc_inc;
                    state_next.status[pcp_pkg::ST_TIMEOUT] = 1'b1;
                    state_next.status[pcp_pkg::ST_HALT] = 1'b1;
                end
                pcp_pkg::OP_FLAGS: begin
                    state_next.pc = pc_inc;
                    // Mask in arg[5:3], values in arg[2:0]
                    if (op_arg[3 + pcp_pkg::ST_ZERO]) begin
                        state_next.status[pcp_pkg::ST_ZERO] = op_arg[pcp_pkg::ST_ZERO];
                    end
                    if (op_arg[3 + pcp_pkg::ST_NIBBLE_CARRY]) begin
                        state_next.status[pcp_pkg::ST_NIBBLE_CARRY] = op_arg[pcp_pkg::ST_NIBBLE_CARRY];
                    end
                    if (op_arg[3 + pcp_pkg::ST_CARRY]) begin
                        state_next.status[pcp_pkg::ST_CARRY] = op_arg[pcp_pkg::ST_CARRY];
                    end
                end
                default: begin
                    state_next.pc = pc_inc;
                end
            endcase
            if (rewrite && state_reg.cfg[pcp_pkg::CFG_TWO_CYCLE]) begin
                state_next.seq = pcp_pkg::SEQ_REWRITE;
                state_next.op_ready = 1'b0;
            end
        end

        // APB slave: one wait state, answer registered
        access = psel && penable;
        idx = paddr[pcp_pkg::PADDR_W-1:2];
        daddr = resolve_addr(idx, state_reg.rbp);
        bus_ok = (paddr[1:0] == 2'h0) && (is_data_addr(idx) || (idx == pcp_pkg::IDX_SEQ_CONFIG) ||
            (idx == pcp_pkg::IDX_STACK_INFO));
        bus_answer = access && !state_reg.pready;
        bus_write = access && state_reg.pready && pwrite && !state_reg.pslverr;
        state_next.pready = bus_answer;
        if (bus_answer) begin
            state_next.pslverr = !bus_ok;
            state_next.prdata = 32'h0;
            if (!pwrite && bus_ok) begin
                if (idx == pcp_pkg::IDX_SEQ_CONFIG) begin
                    state_next.prdata = {30'h0, state_reg.cfg};
                end else if (idx == pcp_pkg::IDX_STACK_INFO) begin
                    state_next.prdata = stack_info(state_reg);
                end else begin
                    state_next.prdata = data_read(daddr, state_reg);
                end
            end
        end

        // Bus write lands after instruction effects and wins over all but a same-cycle stack flag event
        if (bus_write) begin
            if (idx == pcp_pkg::IDX_SEQ_CONFIG) begin
                state_next.cfg = pwdata[1:0];
            end else if (idx == pcp_pkg::IDX_STACK_INFO) begin
                // Write one to clear; an event in the same cycle is kept
                if (pwdata[pcp_pkg::SI_OVERFLOW] && !call_overflow) begin
                    state_next.overflow = 1'b0;
                end
                if (pwdata[pcp_pkg::SI_UNDERFLOW] && !exit_underflow) begin
                    state_next.underflow = 1'b0;
                end
            end else if (daddr == pcp_pkg::IDX_PROGRAM_COUNTER[5:0]) begin
                state_next.pc = {state_next.status[pcp_pkg::ST_PAGE_HI:pcp_pkg::ST_PAGE_LO],
                    state_reg.pc[9:8], pwdata[7:0]};
            end else if (daddr == pcp_pkg::IDX_STATUS_FLAGS[5:0]) begin
                state_next.status = (pwdata[7:0] & pcp_pkg::STATUS_SW_MASK) |
                    (state_next.status & ~pcp_pkg::STATUS_SW_MASK);
            end else if (daddr == pcp_pkg::IDX_RAM_BANK_POINTER[5:0]) begin
                state_next.rbp = pwdata[7:0];
            end else if (daddr >= pcp_pkg::IDX_BANKED_FIRST[5:0]) begin
                state_next.banked[bank_index(daddr, state_reg.rbp)] = pwdata[7:0];
            end else if (daddr >= pcp_pkg::IDX_COMMON_FIRST[5:0]) begin
                state_next.common[daddr[COMMON_W-1:0]] = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign op_ready = state_reg.op_ready;
    assign op_ack = state_reg.op_ack;
    assign instr_tick = state_reg.tick;
    assign exit_literal_load = state_reg.lit_load;
    assign exit_literal = state_reg.lit;
    assign irq_exit = state_reg.irq_exit;
    assign pc_addr = state_reg.pc;
    assign status_out = state_reg.status;
    assign ram_bank_out = state_reg.rbp;

endmodule : pcp_sequencer

// ### logic/pcp_pkg.sv
// Shared constants and types of the program sequencing block
package pcp_pkg;

    // Widths
    localparam int PC_W = 13;
    localparam int PAGE_LO_W = 10;
    localparam int PAGE_W = 3;
    localparam int BYTE_W = 8;
    localparam int ARG_W = 10;
    localparam int PADDR_W = 12;
    localparam int DADDR_W = 6;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_INDIRECT_SLOT = 10'h000;
    localparam logic [9:0] IDX_PROGRAM_COUNTER = 10'h002;
    localparam logic [9:0] IDX_STATUS_FLAGS = 10'h003;
    localparam logic [9:0] IDX_RAM_BANK_POINTER = 10'h004;
    localparam logic [9:0] IDX_COMMON_FIRST = 10'h010;
    localparam logic [9:0] IDX_BANKED_FIRST = 10'h020;
    localparam logic [9:0] IDX_DATA_LAST = 10'h03f;
    localparam logic [9:0] IDX_SEQ_CONFIG = 10'h040;
    localparam logic [9:0] IDX_STACK_INFO = 10'h041;

    // Status field positions
    localparam int ST_PAGE_HI = 7;
    localparam int ST_PAGE_LO = 5;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_HALT = 3;
    localparam int ST_ZERO = 2;
    localparam int ST_NIBBLE_CARRY = 1;
    localparam int ST_CARRY = 0;
    localparam logic [7:0] STATUS_SW_MASK = 8'he7;

    // RAM bank pointer field positions
    localparam int RBP_BANK_HI = 7;
    localparam int RBP_BANK_LO = 6;

    // Sequencer configuration fields
    localparam int CFG_TWO_CYCLE = 0;
    localparam int CFG_SLOW_CLK = 1;

    // Stack info fields
    localparam int SI_OVERFLOW = 6;
    localparam int SI_UNDERFLOW = 7;

    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] RBP_RST = 8'h00;
    localparam logic [1:0] CFG_RST = 2'h0;

    // Last divider count of an instruction cycle, one below its length in clocks
    localparam logic [1:0] DIV_FAST_LAST = 2'h1;
    localparam logic [1:0] DIV_SLOW_LAST = 2'h3;

    // Operations issued by the execute stage
    typedef enum logic [3:0] {
        OP_STEP = 4'h0,
        OP_JUMP = 4'h1,
        OP_CALL = 4'h2,
        OP_EXIT = 4'h3,
        OP_EXIT_LIT = 4'h4,
        OP_EXIT_IRQ = 4'h5,
        OP_ADD_PC = 4'h6,
        OP_MOV_PC = 4'h7,
        OP_WRITE_PC = 4'h8,
        OP_SLEEP = 4'h9,
        OP_WDT_CLEAR = 4'ha,
        OP_FLAGS = 4'hb
    } pcp_op_t;

    typedef enum logic [0:0] {
        SEQ_RUN = 1'b0,
        SEQ_REWRITE = 1'b1
    } pcp_seq_t;

endpackage : pcp_pkg

// ### testbench/pcp_sequencer_assertions.sv
// Port-level checks on the program sequencing block
`timescale 1ns/1ps
module pcp_sequencer_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcp_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic op_valid,
    input wire pcp_pkg::pcp_op_t op_code,
    input wire logic [pcp_pkg::ARG_W-1:0] op_arg,
    input wire logic wdt_timeout,
    input wire logic op_ready,
    input wire logic op_ack,
    input wire logic instr_tick,
    input wire logic exit_literal_load,
    input wire logic [pcp_pkg::BYTE_W-1:0] exit_literal,
    input wire logic irq_exit,
    input wire logic [pcp_pkg::PC_W-1:0] pc_addr,
    input wire logic [pcp_pkg::BYTE_W-1:0] status_out,
    input wire logic [pcp_pkg::BYTE_W-1:0] ram_bank_out
);
    logic take;
    assign take = instr_tick & op_valid & op_ready;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_reset_pc;
        $rose(presetn) |-> pc_addr == 13'h0000;
    endproperty
    a_reset_pc: assert property (p_reset_pc) else $error("counter not clear after reset");
    property p_branch_load;
        take && op_code inside {pcp_pkg::OP_JUMP, pcp_pkg::OP_CALL}
            |=> pc_addr == {$past(status_out[7:5]), $past(op_arg)};
    endproperty
    a_branch_load: assert property (p_branch_load) else $error("jump or call target wrong");
    property p_exit_page;
        take && op_code inside {pcp_pkg::OP_EXIT, pcp_pkg::OP_EXIT_LIT, pcp_pkg::OP_EXIT_IRQ}
            |=> $stable(status_out[7:5]);
    endproperty
    a_exit_page: assert property (p_exit_page) else $error("exit changed page select");
    property p_mov_keep;
        take && op_code inside {pcp_pkg::OP_MOV_PC, pcp_pkg::OP_WRITE_PC}
            |=> pc_addr == {$past(status_out[7:5]), $past(pc_addr[9:8]), $past(op_arg[7:0])};
    endproperty
    a_mov_keep: assert property (p_mov_keep) else $error("counter write lost bits 9:8");
    property p_add_carry;
        take && op_code == pcp_pkg::OP_ADD_PC
            |=> pc_addr[9:0] == $past(pc_addr[9:0]) + 10'h001 + {2'h0, $past(op_arg[7:0])};
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("counter add wrong");
    property p_ack;
        take |=> op_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("no acknowledge after op");
    property p_tick_gap;
        instr_tick |=> !instr_tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("instruction tick too close");
    property p_sleep;
        take && op_code == pcp_pkg::OP_SLEEP |=> status_out[4:3] == 2'b10;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    property p_wdt_clear;
        take && op_code == pcp_pkg::OP_WDT_CLEAR |=> status_out[4:3] == 2'b11;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear flags wrong");
    property p_timeout;
        wdt_timeout && !(take && op_code inside {pcp_pkg::OP_SLEEP, pcp_pkg::OP_WDT_CLEAR})
            |=> !status_out[4];
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag not cleared");
    property p_literal;
        take && op_code == pcp_pkg::OP_EXIT_LIT
            |=> exit_literal_load && op_ack && exit_literal == $past(op_arg[7:0]);
    endproperty
    a_literal: assert property (p_literal) else $error("literal exit wrong");
endmodule : pcp_sequencer_assertions

bind pcp_sequencer pcp_sequencer_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
    .op_code(op_code), .op_arg(op_arg), .wdt_timeout(wdt_timeout), .op_ready(op_ready), .op_ack(op_ack),
    .instr_tick(instr_tick), .exit_literal_load(exit_literal_load), .exit_literal(exit_literal),
    .irq_exit(irq_exit), .pc_addr(pc_addr), .status_out(status_out), .ram_bank_out(ram_bank_out)
);

// ### testbench/pcp_sequencer_bench.sv
// Directed bench for the program sequencing block
`timescale 1ns/1ps
module pcp_sequencer_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, op_valid = 0, wdt_timeout = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, op_ready, op_ack, instr_tick, exit_literal_load, irq_exit, lit_ld, irq_ex, rdy, e;
    pcp_pkg::pcp_op_t op_code = pcp_pkg::OP_STEP;
    pcp_pkg::pcp_op_t codes [3] = '{pcp_pkg::OP_EXIT, pcp_pkg::OP_EXIT_LIT, pcp_pkg::OP_EXIT_IRQ};
    logic [9:0] op_arg = 10'h000;
    logic [7:0] exit_literal, status_out, ram_bank_out;
    logic [12:0] pc_addr;
    int n_fail = 0, cmp_count = 0, n;

    pcp_sequencer dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
        .op_code(op_code), .op_arg(op_arg), .wdt_timeout(wdt_timeout), .op_ready(op_ready), .op_ack(op_ack),
        .instr_tick(instr_tick), .exit_literal_load(exit_literal_load), .exit_literal(exit_literal),
        .irq_exit(irq_exit), .pc_addr(pc_addr), .status_out(status_out), .ram_bank_out(ram_bank_out)
    );

    initial forever #50 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        @(posedge pclk);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask : rd

    task automatic op(input pcp_pkg::pcp_op_t c, input logic [9:0] a);
        @(posedge pclk);
        op_valid <= 1'b1;
        op_code <= c;
        op_arg <= a;
        @(posedge pclk);
        while (op_ack !== 1'b1) begin
            @(posedge pclk);
        end
        lit_ld = exit_literal_load;
        irq_ex = irq_exit;
        rdy = op_ready;
        op_valid <= 1'b0;
    endtask : op

    task automatic tally_and_finish;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        #2000000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h008, 32'h0);
        rd(12'h00c, 32'h18);
        rd(12'h010, 32'h0);
        $display("test reset done");
        wr(12'h00c, 32'ha0);
        chk(status_out, 32'hb8);
        op(pcp_pkg::OP_JUMP, 10'h155);
        chk(pc_addr, 32'h1555);
        op(pcp_pkg::OP_CALL, 10'h3ff);
        chk(pc_addr, 32'h17ff);
        wr(12'h00c, 32'h40);
        op(pcp_pkg::OP_EXIT, 10'h0);
        chk(pc_addr, 32'h1556);
        chk(status_out[7:5], 32'h2);
        op(pcp_pkg::OP_STEP, 10'h0);
        op(pcp_pkg::OP_ADD_PC, 10'h0ff);
        chk(pc_addr, 32'ha57);
        op(pcp_pkg::OP_MOV_PC, 10'h034);
        chk(pc_addr, 32'ha34);
        op(pcp_pkg::OP_WRITE_PC, 10'h1ff);
        chk(pc_addr, 32'haff);
        wr(12'h008, 32'h12);
        chk(pc_addr, 32'ha12);
        $display("test branch done");
        for (int p = 0; p < 8; p++) begin
            wr(12'h00c, 32'(p << 5));
            op(pcp_pkg::OP_JUMP, 10'h3ff);
            chk(pc_addr, 32'(p * 1024 + 1023));
        end
        $display("test pages done");
        wr(12'h00c, 32'h0);
        op(pcp_pkg::OP_JUMP, 10'h0);
        for (int i = 1; i <= 9; i++) op(pcp_pkg::OP_CALL, 10'(i * 16));
        for (int k = 0; k < 8; k++) begin
            op(codes[k % 3], 10'(k));
            chk(pc_addr, 32'(129 - 16 * k));
            chk({lit_ld, irq_ex}, 32'(k % 3 == 1 ? 2 : (k % 3 == 2 ? 1 : 0)));
            if (k % 3 == 1) chk(exit_literal, 32'(k));
        end
        apb(1'b0, 12'h104, 32'h0);
        chk(r & 32'h40, 32'h40);
        op(pcp_pkg::OP_EXIT, 10'h0);
        rd(12'h104, 32'hc0);
        wr(12'h104, 32'hc0);
        rd(12'h104, 32'h0);
        $display("test stack done");
        op(pcp_pkg::OP_FLAGS, 10'h03d);
        @(posedge pclk);
        chk(status_out[4:0], 32'h1d);
        op(pcp_pkg::OP_SLEEP, 10'h0);
        @(posedge pclk);
        chk(status_out[4:0], 32'h15);
        wdt_timeout <= 1'b1;
        @(posedge pclk);
        wdt_timeout <= 1'b0;
        @(posedge pclk);
        chk(status_out[4:0], 32'h05);
        op(pcp_pkg::OP_WDT_CLEAR, 10'h0);
        @(posedge pclk);
        chk(status_out[4:0], 32'h1d);
        $display("test status done");
        wr(12'h010, 32'h40);
        wr(12'h094, 32'h5a);
        wr(12'h010, 32'h65);
        chk(ram_bank_out, 32'h65);
        rd(12'h000, 32'h5a);
        wr(12'h010, 32'h0);
        rd(12'h000, 32'h0);
        rd(12'h200, 32'h0);
        chk(e, 32'h1);
        $display("test bank done");
        wr(12'h100, 32'h3);
        op(pcp_pkg::OP_JUMP, 10'h2aa);
        chk(rdy, 32'h0);
        chk(pc_addr, 32'h2aa);
        repeat (2) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (instr_tick !== 1'b1 && n < 20);
        end
        chk(n, 32'h4);
        $display("test timing done");
        tally_and_finish();
    end
endmodule : pcp_sequencer_bench
